// ===== dv/ulcm_bsc_model.sv
`timescale 1ns/1ps

module ulcm_bsc_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // settings chosen by the test
    input wire logic cfgEnFull,
    input wire logic [2:0] cfgTn,
    input wire logic [4:0] cfgPeriod,
    // configuration towards the block
    output logic idleEnFull,
    output logic idleEnHalf,
    output logic [39:0] idleAvgPeriod,
    output logic [23:0] idleThresh,
    // reports from the block
    input wire logic measValid,
    input wire logic resIndValid,
    input wire logic [2:0] resIndBand,
    // what has been received
    output int measCnt,
    output int resCnt,
    output logic [2:0] lastBand
);
    // half rate stays off so only the chosen full-rate slot runs idle measurement
    assign idleEnFull = cfgEnFull;
    assign idleEnHalf = 1'b0;

    // window length for one slot only, every other slot left at zero
    always_comb begin
        idleAvgPeriod = '0;
        idleAvgPeriod[5 * cfgTn +: 5] = cfgPeriod;
    end

    // ascending band edges 10, 20, 30, 40
    assign idleThresh = {6'h28, 6'h1e, 6'h14, 6'h0a};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            measCnt <= 0;
            resCnt <= 0;
            lastBand <= 3'h0;
        end else begin
            if (measValid) begin
                measCnt <= measCnt + 1;
            end
            if (resIndValid) begin
                resCnt <= resCnt + 1;
                lastBand <= resIndBand;
            end
        end
    end
endmodule

// ===== dv/ulcm_meas_tb_top.sv
`timescale 1ns/1ps

module ulcm_meas_tb_top import ulcm_pkg::*; ;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] chanActive = 8'h3d;
    logic [15:0] chanComb = 16'h0e50;
    logic [7:0] chanData = 8'h08;
    logic burstValid = 1'b0;
    logic [2:0] burstTn = 3'h0;
    logic burstSub = 1'b0;
    ulcm_kind_type burstKind = KIND_TCH;
    logic [23:0] burstMeanSq = 24'h000001;
    logic [7:0] burstErrBits = 8'h00;
    logic [7:0] burstBits = 8'h64;
    logic periodEnd = 1'b0;
    logic [2:0] periodTn = 3'h0;
    logic periodSub = 1'b0;
    logic idleValid = 1'b0;
    logic [2:0] idleTn = 3'h6;
    logic [23:0] idleMeanSq = 24'h000001;
    logic cfgEnFull = 1'b1;
    logic [4:0] cfgPeriod = 5'h03;
    logic idleEnFull, idleEnHalf, measValid, measSub, measComplete, resIndValid;
    logic [39:0] idleAvgPeriod;
    logic [23:0] idleThresh;
    logic [2:0] measTn, rxqualFull, rxqualSub, resIndTn, resIndBand, lastBand;
    logic [5:0] rxlevFull, rxlevSub, resIndLevel;
    int measCnt, resCnt;
    int mismatches = 0;
    int testsRun = 0;

    always #5 clk = ~clk;

    ulcm_meas dut (.clk, .nrst, .chanActive, .chanComb, .chanData, .burstValid, .burstTn, .burstSub, .burstKind,
        .burstMeanSq, .burstErrBits, .burstBits, .periodEnd, .periodTn, .periodSub, .idleEnFull, .idleEnHalf,
        .idleAvgPeriod, .idleThresh, .idleValid, .idleTn, .idleMeanSq, .measValid, .measTn, .measSub, .rxlevFull,
        .rxlevSub, .rxqualFull, .rxqualSub, .measComplete, .resIndValid, .resIndTn, .resIndBand, .resIndLevel);

    ulcm_bsc_model bsc (.clk, .nrst, .cfgEnFull, .cfgTn(3'h6), .cfgPeriod, .idleEnFull, .idleEnHalf, .idleAvgPeriod,
        .idleThresh, .measValid, .resIndValid, .resIndBand, .measCnt, .resCnt, .lastBand);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // valid is left high between calls; endPeriod drops it
    task automatic burstN(input logic [2:0] tn, input logic sub, input ulcm_kind_type kind, input logic [7:0] n,
            input logic [4:0] m, input logic [7:0] err);
        for (int i = 0; i < n; i++) begin
            burstValid = 1'b1;
            burstTn = tn;
            burstSub = sub;
            burstKind = kind;
            burstMeanSq = 24'h000001 << m;
            burstErrBits = err;
            @(negedge clk);
        end
    endtask

    task automatic endPeriod(input logic [2:0] tn, input logic sub, input logic [5:0] lf, ls,
            input logic [2:0] qf, qs, input logic comp);
        burstValid = 1'b0;
        periodEnd = 1'b1;
        periodTn = tn;
        periodSub = sub;
        @(negedge clk);
        periodEnd = 1'b0;
        check(measValid, 1'b1);
        check({measTn, measSub, rxlevFull, rxlevSub, rxqualFull, rxqualSub, measComplete},
            {tn, sub, lf, ls, qf, qs, comp});
        @(negedge clk);
        check(measValid, 1'b0);
    endtask

    // level 2^m codes to 3m-20; errors e of 100 bits give quality steps with 10e >= 2^k
    task automatic combI();
        burstN(3'h0, 1'b0, KIND_TCH, 8'h58, 5'h10, 8'h01);
        burstN(3'h0, 1'b0, KIND_SID, 8'h08, 5'h10, 8'h01);
        burstN(3'h0, 1'b0, KIND_SACCH, 8'h04, 5'h10, 8'h01);
        endPeriod(3'h0, 1'b0, 6'h1c, 6'h1c, 3'h3, 3'h3, 1'b1);
        burstN(3'h0, 1'b0, KIND_TCH, 8'h58, 5'h10, 8'h01);
        burstN(3'h0, 1'b0, KIND_SID, 8'h08, 5'h10, 8'h01);
        burstN(3'h0, 1'b0, KIND_SACCH, 8'h03, 5'h10, 8'h01);
        endPeriod(3'h0, 1'b0, 6'h1c, 6'h1c, 3'h3, 3'h3, 1'b0);
        $display("done combI");
    endtask

    task automatic combII();
        burstN(3'h2, 1'b1, KIND_TCH, 8'h28, 5'h14, 8'h02);
        burstN(3'h2, 1'b1, KIND_SID, 8'h08, 5'h14, 8'h02);
        burstN(3'h2, 1'b1, KIND_SACCH, 8'h04, 5'h14, 8'h02);
        endPeriod(3'h2, 1'b1, 6'h28, 6'h28, 3'h4, 3'h4, 1'b1);
        burstN(3'h3, 1'b0, KIND_TCH, 8'h26, 5'h0c, 8'h00);
        burstN(3'h3, 1'b0, KIND_SID, 8'h0a, 5'h0c, 8'h00);
        burstN(3'h3, 1'b0, KIND_SACCH, 8'h04, 5'h0c, 8'h00);
        endPeriod(3'h3, 1'b0, 6'h10, 6'h10, 3'h0, 3'h0, 1'b1);
        $display("done combII");
    endtask

    task automatic combCtrl();
        burstN(3'h4, 1'b0, KIND_SDCCH, 8'h08, 5'h17, 8'h0d);
        burstN(3'h4, 1'b0, KIND_SACCH, 8'h04, 5'h17, 8'h0d);
        endPeriod(3'h4, 1'b0, 6'h31, 6'h31, 3'h7, 3'h7, 1'b1);
        burstN(3'h5, 1'b0, KIND_SDCCH, 8'h08, 5'h16, 8'h00);
        burstN(3'h5, 1'b0, KIND_SACCH, 8'h04, 5'h16, 8'h00);
        endPeriod(3'h5, 1'b0, 6'h2e, 6'h2e, 3'h0, 3'h0, 1'b1);
        $display("done combCtrl");
    endtask

    // full mean of 174 and 171 biased is 172.5, so truncation would show as 26
    task automatic mixed();
        burstN(3'h0, 1'b0, KIND_TCH, 8'h01, 5'h10, 8'h00);
        burstN(3'h4, 1'b0, KIND_SDCCH, 8'h01, 5'h17, 8'h00);
        burstN(3'h0, 1'b0, KIND_SACCH, 8'h01, 5'h0f, 8'h02);
        endPeriod(3'h0, 1'b0, 6'h1b, 6'h19, 3'h3, 3'h4, 1'b0);
        endPeriod(3'h4, 1'b0, 6'h31, 6'h31, 3'h0, 3'h0, 1'b0);
        // subchannel 0 of slot 2 never saw a burst: empty period codes as zero
        endPeriod(3'h2, 1'b0, 6'h00, 6'h00, 3'h0, 3'h0, 1'b0);
        $display("done mixed");
    endtask

    task automatic inactive();
        int n0;
        n0 = measCnt;
        burstN(3'h7, 1'b0, KIND_TCH, 8'h02, 5'h10, 8'h00);
        burstValid = 1'b0;
        periodEnd = 1'b1;
        periodTn = 3'h7;
        @(negedge clk);
        periodEnd = 1'b0;
        check(measValid, 1'b0);
        @(negedge clk);
        check(measCnt, n0);
        $display("done inactive");
    endtask

    task automatic idleSample(input logic [4:0] m, input logic rep, input logic [2:0] band, input logic [5:0] lev);
        idleValid = 1'b1;
        idleMeanSq = 24'h000001 << m;
        @(negedge clk);
        idleValid = 1'b0;
        @(negedge clk);
        check(resIndValid, rep);
        if (rep) begin
            check({resIndTn, resIndBand, resIndLevel}, {3'h6, band, lev});
        end
        @(negedge clk);
    endtask

    task automatic idle();
        int n0;
        idleSample(5'h0a, 1'b0, 3'h0, 6'h00);
        idleSample(5'h0a, 1'b1, 3'h1, 6'h0a);
        idleSample(5'h0e, 1'b0, 3'h1, 6'h0e);
        idleSample(5'h0e, 1'b0, 3'h1, 6'h12);
        idleSample(5'h0e, 1'b1, 3'h2, 6'h16);
        cfgEnFull = 1'b0;
        cfgPeriod = 5'h02;
        n0 = resCnt;
        idleSample(5'h14, 1'b0, 3'h0, 6'h00);
        idleSample(5'h14, 1'b0, 3'h0, 6'h00);
        check(resCnt, n0);
        cfgEnFull = 1'b1;
        @(negedge clk);
        idleSample(5'h14, 1'b0, 3'h0, 6'h00);
        idleSample(5'h14, 1'b1, 3'h4, 6'h28);
        idleSample(5'h0f, 1'b1, 3'h3, 6'h21);
        $display("done idle");
    endtask

    initial begin
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        check({measValid, resIndValid, rxlevFull, resIndBand, measComplete}, 12'h000);
        combI();
        combII();
        combCtrl();
        mixed();
        inactive();
        idle();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("BAD t=%0t run limit reached", $time);
        summarize();
    end
endmodule

// ===== verilog/ulcm_consts.svh
`ifndef ULCM_CONSTS_SVH
`define ULCM_CONSTS_SVH

// level values travel biased: stored value = dBm + 256
`define ULCM_LEV_BIAS 16'h0100
// biased value of -110 dBm, where the level code leaves zero
`define ULCM_RXLEV_ZERO_POS 16'h0092
`define ULCM_RXLEV_MAX 16'h003f
// default biased dBm of an all-zero log term
`define ULCM_LEV_CAL_POS 9'h07e

// frames per reporting period
`define ULCM_TCH_FULL_FR 8'h60
`define ULCM_TCH_FULL_HR 8'h30
`define ULCM_SACCH_FR 8'h04
`define ULCM_SID_SPEECH 8'h08
`define ULCM_SID_DATA 8'h0a
`define ULCM_SDCCH_FR 8'h08
// samples in the window when the first idle average is produced
`define ULCM_FIRST_AVG_CNT 5'h02

// bit error ratio in per mille, lowest quality step at 0.2 %
`define ULCM_BER_SCALE 32'h000003e8
`define ULCM_BER_STEPS 7
`define ULCM_BANDS 5

`endif

// ===== verilog/ulcm_meas.sv
// Notes on behaviour
// - each active uplink burst yields an RMS power level at the antenna reference.
// - burst levels become dBm, are averaged per period, then coded as RXLEV.
// - bit error ratio is accumulated over the period and coded as RXQUAL.
// - every SACCH burst of an active channel adds to its measurements.
// - period boundaries are kept per timeslot and per subchannel.
// - full-rate traffic: full 96+4 frames, sub 8 SID+4 SACCH.
// - half-rate: full 48+4 frames, speech sub 8 SID+4 SACCH.
// - half-rate data: sub 10 SID+4 SACCH.
// - control combinations: full and sub both 8 SDCCH+4 SACCH.
// - active results leave as a measurement result report.
// - both reports go out in the period after the measured one.
// - idle measurement on or off per full/half rate, obeyed by the block.
// - controller gives per-timeslot window length in measurement periods.
// - idle level: RMS, log in dBm, coded like RXLEV before averaging.
// - first idle average after two completed measurement periods.
// - second idle average when the first full window completes.
// - afterwards each new sample replaces the oldest and recomputes.
// - each idle average falls in exactly one of five bands.
// - resource report on first average, then only on band change.
// - full values span the whole multiframe, sub values a subset.
`timescale 1ns/1ps
`include "ulcm_consts.svh"

module ulcm_meas import ulcm_pkg::*; #(
    parameter int WIN_DEPTH = 32,
    parameter logic [8:0] LEV_CAL_POS = `ULCM_LEV_CAL_POS
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // channel configuration
    input wire logic [7:0] chanActive,
    input wire logic [15:0] chanComb,
    input wire logic [7:0] chanData,
    // burst results from the receiver
    input wire logic burstValid,
    input wire logic [2:0] burstTn,
    input wire logic burstSub,
    input wire ulcm_kind_type burstKind,
    input wire logic [23:0] burstMeanSq,
    input wire logic [7:0] burstErrBits,
    input wire logic [7:0] burstBits,
    // reporting period boundaries
    input wire logic periodEnd,
    input wire logic [2:0] periodTn,
    input wire logic periodSub,
    // idle measurement
    input wire logic idleEnFull,
    input wire logic idleEnHalf,
    input wire logic [39:0] idleAvgPeriod,
    input wire logic [23:0] idleThresh,
    input wire logic idleValid,
    input wire logic [2:0] idleTn,
    input wire logic [23:0] idleMeanSq,
    // measurement result
    output logic measValid,
    output logic [2:0] measTn,
    output logic measSub,
    output logic [5:0] rxlevFull,
    output logic [5:0] rxlevSub,
    output logic [2:0] rxqualFull,
    output logic [2:0] rxqualSub,
    output logic measComplete,
    // resource indication
    output logic resIndValid,
    output logic [2:0] resIndTn,
    output logic [2:0] resIndBand,
    output logic [5:0] resIndLevel
);
    localparam int WAW = $clog2(WIN_DEPTH);

    // log2 in eighths by leading one, times 3 for dB (3.01 dB per octave)
    function automatic logic [8:0] levelPos(input logic [23:0] ms);
        logic [4:0] msb;
        logic [23:0] sh;
        logic [9:0] q;
        msb = '0;
        for (int i = 0; i < 24; i++) begin
            if (ms[i]) begin
                msb = 5'(i);
            end
        end
        sh = ms << (5'd23 - msb);
        q = 10'({msb, sh[22:20]}) * 10'd3;
        levelPos = 9'((q + 10'd4) >> 3) + LEV_CAL_POS;
    endfunction

    function automatic logic [15:0] divRound(input logic [15:0] sum, input logic [7:0] cnt);
        if (cnt == 8'h00) begin
            divRound = '0;
        end else begin
            divRound = 16'((17'(sum) + 17'(cnt >> 1)) / 17'(cnt));
        end
    endfunction

    function automatic logic [5:0] rxlevOf(input logic [15:0] pos);
        if (pos < `ULCM_RXLEV_ZERO_POS) begin
            rxlevOf = '0;
        end else if (pos - `ULCM_RXLEV_ZERO_POS > `ULCM_RXLEV_MAX) begin
            rxlevOf = 6'h3f;
        end else begin
            rxlevOf = 6'(pos - `ULCM_RXLEV_ZERO_POS);
        end
    endfunction

    function automatic logic [2:0] rxqualOf(input logic [15:0] err, input logic [15:0] bits);
        logic [31:0] e;
        logic [31:0] b;
        e = 32'(err) * `ULCM_BER_SCALE;
        b = 32'(bits);
        rxqualOf = '0;
        for (int k = 0; k < `ULCM_BER_STEPS; k++) begin
            if (bits != 16'h0000 && e >= (b << (k + 1))) begin
                rxqualOf = 3'(k + 1);
            end
        end
    endfunction

    function automatic ulcm_acc_type accAdd(input ulcm_acc_type a, input logic [8:0] lev,
                                            input logic [7:0] err, input logic [7:0] bits);
        accAdd.levSum = a.levSum + 16'(lev);
        accAdd.errSum = a.errSum + 16'(err);
        accAdd.bitSum = a.bitSum + 16'(bits);
        accAdd.cnt = a.cnt + 8'h01;
    endfunction

    function automatic logic [7:0] expFull(input ulcm_comb_type c);
        case (c)
            COMB_I: expFull = `ULCM_TCH_FULL_FR + `ULCM_SACCH_FR;
            COMB_II: expFull = `ULCM_TCH_FULL_HR + `ULCM_SACCH_FR;
            default: expFull = `ULCM_SDCCH_FR + `ULCM_SACCH_FR;
        endcase
    endfunction

    function automatic logic [7:0] expSub(input ulcm_comb_type c, input logic data);
        case (c)
            COMB_I: expSub = `ULCM_SID_SPEECH + `ULCM_SACCH_FR;
            COMB_II: expSub = (data ? `ULCM_SID_DATA : `ULCM_SID_SPEECH) + `ULCM_SACCH_FR;
            default: expSub = `ULCM_SDCCH_FR + `ULCM_SACCH_FR;
        endcase
    endfunction

    function automatic ulcm_comb_type combOf(input logic [2:0] tn);
        combOf = ulcm_comb_type'(chanComb[tn*2 +: 2]);
    endfunction

    // ---------------- active channel accumulation
    ulcm_acc_type accFull_r [16];
    ulcm_acc_type accSub_r [16];
    ulcm_acc_type accFull_nxt [16];
    ulcm_acc_type accSub_nxt [16];
    logic [3:0] bIdx;
    logic [3:0] pIdx;
    logic burstHit;
    logic burstInSub;
    logic [8:0] burstLev;
    ulcm_comb_type bComb;
    ulcm_comb_type pComb;

    assign bIdx = {burstTn, burstSub};
    assign pIdx = {periodTn, periodSub};
    assign bComb = combOf(burstTn);
    assign pComb = combOf(periodTn);
    assign burstHit = burstValid && chanActive[burstTn];
    assign burstLev = levelPos(burstMeanSq);
    // sub set: SID and SACCH frames, or every frame on control channels
    assign burstInSub = burstKind == KIND_SACCH || burstKind == KIND_SID
                        || bComb == COMB_V || bComb == COMB_VII;

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            // a boundary clears the slot; a burst in the same cycle opens the new period
            accFull_nxt[i] = (periodEnd && pIdx == 4'(i)) ? '0 : accFull_r[i];
            accSub_nxt[i] = (periodEnd && pIdx == 4'(i)) ? '0 : accSub_r[i];
            if (burstHit && bIdx == 4'(i)) begin
                // all kinds, SACCH included, go to the full set
                accFull_nxt[i] = accAdd(accFull_nxt[i], burstLev, burstErrBits, burstBits);
                if (burstInSub) begin
                    accSub_nxt[i] = accAdd(accSub_nxt[i], burstLev, burstErrBits, burstBits);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 16; i++) begin
                accFull_r[i] <= '0;
                accSub_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 16; i++) begin
                accFull_r[i] <= accFull_nxt[i];
                accSub_r[i] <= accSub_nxt[i];
            end
        end
    end

    // ---------------- measurement result, issued the cycle after the boundary
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            measValid <= 1'b0;
            measTn <= '0;
            measSub <= 1'b0;
            rxlevFull <= '0;
            rxlevSub <= '0;
            rxqualFull <= '0;
            rxqualSub <= '0;
            measComplete <= 1'b0;
        end else begin
            measValid <= periodEnd && chanActive[periodTn];
            if (periodEnd && chanActive[periodTn]) begin
                measTn <= periodTn;
                measSub <= periodSub;
                rxlevFull <= rxlevOf(divRound(accFull_r[pIdx].levSum, accFull_r[pIdx].cnt));
                rxlevSub <= rxlevOf(divRound(accSub_r[pIdx].levSum, accSub_r[pIdx].cnt));
                rxqualFull <= rxqualOf(accFull_r[pIdx].errSum, accFull_r[pIdx].bitSum);
                rxqualSub <= rxqualOf(accSub_r[pIdx].errSum, accSub_r[pIdx].bitSum);
                measComplete <= accFull_r[pIdx].cnt == expFull(pComb)
                                && accSub_r[pIdx].cnt == expSub(pComb, chanData[periodTn]);
            end
        end
    end

    // ---------------- idle channel interference
    ulcm_idle_state_type state_r;
    logic [2:0] idleTnSel_r;
    logic [5:0] idleNew_r;
    logic [4:0] winCnt_r [8];
    logic [WAW-1:0] winPtr_r [8];
    logic [11:0] winSum_r [8];
    logic [2:0] lastBand_r [8];
    logic [7:0] haveBand_r;
    logic [7:0] idleAllowed;
    logic [5:0] oldSample;
    logic [WAW+2:0] ramAddr;
    logic [4:0] winLen;
    logic winFull;
    logic [4:0] cntNxt;
    logic [11:0] sumNxt;
    logic [WAW-1:0] ptrNxt;
    logic avgNow;
    logic [5:0] avgLev;
    logic [2:0] bandNow;

    always_comb begin
        for (int t = 0; t < 8; t++) begin
            idleAllowed[t] = !chanActive[t] && idleAvgPeriod[t*5 +: 5] != 5'h00
                             && ((combOf(3'(t)) == COMB_I && idleEnFull)
                             || (combOf(3'(t)) == COMB_II && idleEnHalf));
        end
    end

    assign ramAddr = state_r == ST_WAIT ? {idleTn, winPtr_r[idleTn]} : {idleTnSel_r, winPtr_r[idleTnSel_r]};
    assign winLen = idleAvgPeriod[idleTnSel_r*5 +: 5];
    assign winFull = winCnt_r[idleTnSel_r] >= winLen;
    // once full, the oldest sample sits at the write pointer and is replaced
    assign sumNxt = winFull ? winSum_r[idleTnSel_r] - 12'(oldSample) + 12'(idleNew_r)
                            : winSum_r[idleTnSel_r] + 12'(idleNew_r);
    assign cntNxt = winFull ? winLen : winCnt_r[idleTnSel_r] + 5'h01;
    assign ptrNxt = (32'(winPtr_r[idleTnSel_r]) + 1 >= 32'(winLen)) ? '0 : winPtr_r[idleTnSel_r] + 1'b1;
    assign avgNow = cntNxt == `ULCM_FIRST_AVG_CNT || cntNxt == winLen;
    assign avgLev = 6'(divRound(16'(sumNxt), 8'(cntNxt)));

    always_comb begin
        bandNow = '0;
        for (int k = 0; k < `ULCM_BANDS - 1; k++) begin
            if (avgLev >= idleThresh[k*6 +: 6]) begin
                bandNow = 3'(k + 1);
            end
        end
    end

    ulcm_sample_ram #(
        .WIDTH(6),
        .AW(WAW + 3)
    ) u_ram (
        .clk(clk),
        .we(state_r == ST_UPD),
        .addr(ramAddr),
        .wrData(idleNew_r),
        .rdData(oldSample)
    );

    // samples arriving while an update is in flight are dropped
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_WAIT;
            idleTnSel_r <= '0;
            idleNew_r <= '0;
        end else begin
            case (state_r)
                ST_WAIT: begin
                    if (idleValid && idleAllowed[idleTn]) begin
                        state_r <= ST_UPD;
                        idleTnSel_r <= idleTn;
                        idleNew_r <= rxlevOf(16'(levelPos(idleMeanSq)));
                    end
                end
                default: begin
                    state_r <= ST_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int t = 0; t < 8; t++) begin
                winCnt_r[t] <= '0;
                winPtr_r[t] <= '0;
                winSum_r[t] <= '0;
                lastBand_r[t] <= '0;
            end
            haveBand_r <= '0;
        end else begin
            if (state_r == ST_UPD) begin
                winCnt_r[idleTnSel_r] <= cntNxt;
                winSum_r[idleTnSel_r] <= sumNxt;
                winPtr_r[idleTnSel_r] <= ptrNxt;
                if (avgNow) begin
                    lastBand_r[idleTnSel_r] <= bandNow;
                    haveBand_r[idleTnSel_r] <= 1'b1;
                end
            end
            // switching off or activating a slot restarts its window
            for (int t = 0; t < 8; t++) begin
                if (!idleAllowed[t]) begin
                    winCnt_r[t] <= '0;
                    winPtr_r[t] <= '0;
                    winSum_r[t] <= '0;
                    haveBand_r[t] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            resIndValid <= 1'b0;
            resIndTn <= '0;
            resIndBand <= '0;
            resIndLevel <= '0;
        end else begin
            resIndValid <= state_r == ST_UPD && avgNow && idleAllowed[idleTnSel_r]
                           && (!haveBand_r[idleTnSel_r] || bandNow != lastBand_r[idleTnSel_r]);
            if (state_r == ST_UPD && avgNow) begin
                resIndTn <= idleTnSel_r;
                resIndBand <= bandNow;
                resIndLevel <= avgLev;
            end
        end
    end

    // ---------------- checks
    a_meas_after_end: assert property (@(posedge clk) disable iff (!nrst)
        periodEnd && chanActive[periodTn] |=> measValid && measTn == $past(periodTn) && measSub == $past(periodSub))
        else $error("result not issued the cycle after the boundary");
    a_meas_cause: assert property (@(posedge clk) disable iff (!nrst)
        measValid |-> $past(periodEnd))
        else $error("result without a period boundary");
    a_qual_clean: assert property (@(posedge clk) disable iff (!nrst)
        periodEnd && chanActive[periodTn] && accFull_r[pIdx].errSum == 16'h0000 |=> rxqualFull == 3'h0)
        else $error("error-free period not coded as best quality");
    a_sacch_counted: assert property (@(posedge clk) disable iff (!nrst)
        burstHit && burstKind == KIND_SACCH && !(periodEnd && pIdx == bIdx)
        |=> accFull_r[$past(bIdx)].cnt == $past(accFull_r[bIdx].cnt) + 8'h01)
        else $error("SACCH burst not counted");
    a_rxlev_floor: assert property (@(posedge clk) disable iff (!nrst)
        measValid && $past(accFull_r[pIdx].cnt) == 8'h00 |-> rxlevFull == 6'h00)
        else $error("empty period gave a nonzero level");
    a_band_range: assert property (@(posedge clk) disable iff (!nrst)
        resIndValid |-> resIndBand <= 3'h4)
        else $error("band outside five bands");
    a_first_avg: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_UPD && cntNxt == `ULCM_FIRST_AVG_CNT && !winFull && idleAllowed[idleTnSel_r] |=> resIndValid)
        else $error("no report after two idle periods");
    a_no_repeat: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_UPD && haveBand_r[idleTnSel_r] && bandNow == lastBand_r[idleTnSel_r] |=> !resIndValid)
        else $error("report without band change");
    a_idle_gate: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_WAIT && idleValid && !idleAllowed[idleTn] |=> state_r == ST_WAIT ##1 !resIndValid)
        else $error("disabled slot was measured");
    a_win_cap: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_UPD && winFull |=> winCnt_r[$past(idleTnSel_r)] == $past(winLen))
        else $error("window grew beyond its length");

    c_meas_full: cover property (@(posedge clk) disable iff (!nrst) measValid && measComplete);
    c_first_ind: cover property (@(posedge clk) disable iff (!nrst) resIndValid && resIndBand == 3'h0);
    c_band_move: cover property (@(posedge clk) disable iff (!nrst)
        state_r == ST_UPD && winFull && haveBand_r[idleTnSel_r] && bandNow != lastBand_r[idleTnSel_r]);

endmodule

// ===== verilog/ulcm_pkg.sv
package ulcm_pkg;

    typedef enum logic [1:0] {COMB_I, COMB_II, COMB_V, COMB_VII} ulcm_comb_type;

    typedef enum logic [1:0] {KIND_TCH, KIND_SACCH, KIND_SID, KIND_SDCCH} ulcm_kind_type;

    typedef enum {ST_WAIT, ST_UPD} ulcm_idle_state_type;

    typedef struct packed {
        logic [15:0] levSum;
        logic [15:0] errSum;
        logic [15:0] bitSum;
        logic [7:0] cnt;
    } ulcm_acc_type;

endpackage

// ===== verilog/ulcm_sample_ram.sv
`timescale 1ns/1ps

module ulcm_sample_ram #(
    parameter int WIDTH = 6,
    parameter int AW = 8
) (
    // clock
    input wire logic clk,
    // port
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [WIDTH-1:0] wrData,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem [2**AW];

    // read-before-write: the old sample comes out while the new one lands
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wrData;
        end
        rdData <= mem[addr];
    end

endmodule
